// File: rph_packet_handler.sv
`timescale 1ns/1ps
`default_nettype none
module rph_packet_handler (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic bit_valid,
  input wire logic bit_data,
  output logic bit_ready,
  input wire logic [7:0] rssi,
  output logic fifo_valid,
  input wire logic fifo_ready,
  output logic [7:0] fifo_data,
  output logic fifo_flush,
  output logic [1:0] general_digital_output_pins
);
  typedef struct packed {
    logic [7:0] sync_word_high;
    logic [7:0] sync_word_low;
    logic [7:0] packet_length_limit;
    logic [7:0] packet_filter_control;
    logic [7:0] packet_format_control;
    logic [7:0] node_address;
    logic [7:0] rdata;
    logic [15:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] remain;
    logic [15:0] crc;
    logic crc_ok;
    rph_pkg::rph_phase_t phase;
    logic flush;
    logic [1:0] pins;
  } rph_state_t;

  rph_state_t q;
  rph_state_t next_q;
  logic push_valid;
  logic [7:0] push_data;
  logic buf_ready;
  logic take;
  logic byte_done;
  logic [15:0] shifted;
  logic [7:0] rx_byte;
  logic [1:0] len_cfg;
  logic [1:0] addr_sel;
  logic [1:0] out_fmt;
  logic crc_en;
  logic append_on;
  logic flush_on;
  logic fifo_mode;
  logic stat_phase;
  rph_pkg::rph_phase_t end_phase;

  function automatic logic [15:0] rph_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ rph_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : rph_crc_byte

  function automatic logic rph_addr_ok(input logic [1:0] sel, input logic [7:0] addr,
                                       input logic [7:0] own);
    logic ok;
    ok = (addr == own);
    // broadcast addresses widen the filter
    if (sel == rph_pkg::ADDR_BCAST0 || sel == rph_pkg::ADDR_BCAST_BOTH) begin
      ok = ok || (addr == rph_pkg::BCAST_LOW);
    end
    if (sel == rph_pkg::ADDR_BCAST_BOTH) begin
      ok = ok || (addr == rph_pkg::BCAST_HIGH);
    end
    return ok;
  endfunction : rph_addr_ok

  assign len_cfg = q.packet_format_control[rph_pkg::LSB_LEN_CFG +: 2];
  assign out_fmt = q.packet_format_control[rph_pkg::LSB_OUT_FMT +: 2];
  assign crc_en = q.packet_format_control[rph_pkg::BIT_CRC_EN];
  assign addr_sel = q.packet_filter_control[rph_pkg::LSB_ADDR_SEL +: 2];
  assign append_on = q.packet_filter_control[rph_pkg::BIT_APPEND];
  assign flush_on = q.packet_filter_control[rph_pkg::BIT_FLUSH];
  assign fifo_mode = (out_fmt == rph_pkg::FMT_FIFO);
  assign stat_phase = (q.phase == rph_pkg::RPH_STAT1) || (q.phase == rph_pkg::RPH_STAT2);
  // serial modes never stall; fifo mode stalls on a full buffer
  assign bit_ready = !fifo_mode || (buf_ready && !stat_phase);
  assign take = bit_valid && bit_ready;
  assign shifted = {q.shreg[14:0], bit_data};
  assign rx_byte = shifted[7:0];
  assign byte_done = take && (q.bitcnt == rph_pkg::BIT_LAST);
  assign reg_rdata = q.rdata;
  assign fifo_flush = q.flush;
  assign general_digital_output_pins = q.pins;

  always_comb begin
    if (crc_en) begin
      end_phase = rph_pkg::RPH_CRC1;
    end else if (append_on) begin
      end_phase = rph_pkg::RPH_STAT1;
    end else begin
      end_phase = rph_pkg::RPH_HUNT;
    end
  end

  always_comb begin
    next_q = q;
    next_q.flush = 1'b0;
    push_valid = 1'b0;
    push_data = 8'h00;

    if (reg_wr) begin
      unique case (reg_addr)
        rph_pkg::OFS_SYNC_HIGH: next_q.sync_word_high = reg_wdata;
        rph_pkg::OFS_SYNC_LOW: next_q.sync_word_low = reg_wdata;
        rph_pkg::OFS_LEN_LIMIT: next_q.packet_length_limit = reg_wdata;
        rph_pkg::OFS_FILTER: next_q.packet_filter_control = reg_wdata & rph_pkg::MASK_FILTER;
        rph_pkg::OFS_FORMAT: next_q.packet_format_control = reg_wdata & rph_pkg::MASK_FORMAT;
        rph_pkg::OFS_NODE_ADDR: next_q.node_address = reg_wdata;
        default: next_q.node_address = q.node_address;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        rph_pkg::OFS_SYNC_HIGH: next_q.rdata = q.sync_word_high;
        rph_pkg::OFS_SYNC_LOW: next_q.rdata = q.sync_word_low;
        rph_pkg::OFS_LEN_LIMIT: next_q.rdata = q.packet_length_limit;
        rph_pkg::OFS_FILTER: next_q.rdata = q.packet_filter_control;
        rph_pkg::OFS_FORMAT: next_q.rdata = q.packet_format_control;
        rph_pkg::OFS_NODE_ADDR: next_q.rdata = q.node_address;
        rph_pkg::OFS_STATUS: next_q.rdata = {q.crc_ok, (q.phase != rph_pkg::RPH_HUNT), 6'h00};
        default: next_q.rdata = 8'h00;
      endcase
    end

    if (take) begin
      next_q.shreg = shifted;
    end

    // sync serial: clock pulse with each bit
    if (out_fmt == rph_pkg::FMT_SYNC_SERIAL) begin
      next_q.pins = {take, take ? bit_data : q.pins[0]};
    end else if (out_fmt == rph_pkg::FMT_ASYNC_SERIAL) begin
      next_q.pins = {1'b0, take ? bit_data : q.pins[0]};
    end else begin
      next_q.pins = 2'h0;
    end

    if (take && q.phase != rph_pkg::RPH_HUNT) begin
      next_q.bitcnt = q.bitcnt + rph_pkg::BIT_ONE;
    end
    if (byte_done) begin
      next_q.crc = rph_crc_byte(q.crc, rx_byte);
    end

    unique case (q.phase)
      rph_pkg::RPH_HUNT: begin
        if (take && fifo_mode && shifted == {q.sync_word_high, q.sync_word_low}) begin
          next_q.bitcnt = 3'h0;
          next_q.crc = rph_pkg::CRC_INIT;
          next_q.crc_ok = 1'b0;
          unique case (len_cfg)
            rph_pkg::LEN_FIXED: begin
              next_q.remain = q.packet_length_limit;
              next_q.phase = (addr_sel != rph_pkg::ADDR_NONE) ? rph_pkg::RPH_ADDR
                                                               : rph_pkg::RPH_PAY;
            end
            rph_pkg::LEN_VARIABLE: next_q.phase = rph_pkg::RPH_LEN;
            rph_pkg::LEN_INFINITE: next_q.phase = rph_pkg::RPH_PAY;
            default: next_q.phase = rph_pkg::RPH_HUNT;
          endcase
        end
      end
      rph_pkg::RPH_LEN: begin
        if (byte_done) begin
          if (rx_byte == rph_pkg::LEN_ZERO || rx_byte > q.packet_length_limit) begin
            next_q.phase = rph_pkg::RPH_HUNT;
          end else begin
            push_valid = 1'b1;
            push_data = rx_byte;
            next_q.remain = rx_byte;
            next_q.phase = (addr_sel != rph_pkg::ADDR_NONE) ? rph_pkg::RPH_ADDR
                                                             : rph_pkg::RPH_PAY;
          end
        end
      end
      rph_pkg::RPH_ADDR: begin
        if (byte_done) begin
          if (!rph_addr_ok(addr_sel, rx_byte, q.node_address)) begin
            next_q.flush = 1'b1;
            next_q.phase = rph_pkg::RPH_HUNT;
          end else begin
            push_valid = 1'b1;
            push_data = rx_byte;
            next_q.remain = q.remain - rph_pkg::LEN_ONE;
            next_q.phase = (q.remain == rph_pkg::LEN_ONE) ? end_phase : rph_pkg::RPH_PAY;
          end
        end
      end
      rph_pkg::RPH_PAY: begin
        if (byte_done) begin
          push_valid = 1'b1;
          push_data = rx_byte;
          if (len_cfg != rph_pkg::LEN_INFINITE) begin
            next_q.remain = q.remain - rph_pkg::LEN_ONE;
            if (q.remain == rph_pkg::LEN_ONE) begin
              next_q.phase = end_phase;
            end
          end
        end
      end
      rph_pkg::RPH_CRC1: begin
        if (byte_done) begin
          next_q.phase = rph_pkg::RPH_CRC2;
        end
      end
      rph_pkg::RPH_CRC2: begin
        if (byte_done) begin
          next_q.crc_ok = (rph_crc_byte(q.crc, rx_byte) == rph_pkg::CRC_RESIDUE);
          // relies on a single packet held in the fifo
          if (flush_on && rph_crc_byte(q.crc, rx_byte) != rph_pkg::CRC_RESIDUE) begin
            next_q.flush = 1'b1;
            next_q.phase = rph_pkg::RPH_HUNT;
          end else begin
            next_q.phase = append_on ? rph_pkg::RPH_STAT1 : rph_pkg::RPH_HUNT;
          end
        end
      end
      rph_pkg::RPH_STAT1: begin
        push_valid = 1'b1;
        push_data = rssi;
        if (buf_ready) begin
          next_q.phase = rph_pkg::RPH_STAT2;
        end
      end
      rph_pkg::RPH_STAT2: begin
        push_valid = 1'b1;
        push_data = {q.crc_ok, 7'h00};
        if (buf_ready) begin
          next_q.phase = rph_pkg::RPH_HUNT;
        end
      end
      default: next_q.phase = rph_pkg::RPH_HUNT;
    endcase

    // leaving fifo mode abandons any packet in progress
    if (!fifo_mode) begin
      next_q.phase = rph_pkg::RPH_HUNT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.sync_word_high <= rph_pkg::RST_SYNC_HIGH;
      q.sync_word_low <= rph_pkg::RST_SYNC_LOW;
      q.packet_length_limit <= rph_pkg::RST_LEN_LIMIT;
      q.packet_filter_control <= rph_pkg::RST_FILTER;
      q.packet_format_control <= rph_pkg::RST_FORMAT;
      q.node_address <= rph_pkg::RST_NODE_ADDR;
      q.phase <= rph_pkg::RPH_HUNT;
    end else begin
      q <= next_q;
    end
  end

  rph_pair_buffer u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(q.flush),
    .in_valid(push_valid),
    .in_ready(buf_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );
endmodule : rph_packet_handler
`default_nettype wire

// File: rph_pkg.sv
`default_nettype none
package rph_pkg;
  localparam logic [5:0] OFS_SYNC_HIGH = 6'h04;
  localparam logic [5:0] OFS_SYNC_LOW = 6'h05;
  localparam logic [5:0] OFS_LEN_LIMIT = 6'h06;
  localparam logic [5:0] OFS_FILTER = 6'h07;
  localparam logic [5:0] OFS_FORMAT = 6'h08;
  localparam logic [5:0] OFS_NODE_ADDR = 6'h09;
  localparam logic [5:0] OFS_STATUS = 6'h38;

  localparam logic [7:0] RST_SYNC_HIGH = 8'hd3;
  localparam logic [7:0] RST_SYNC_LOW = 8'h91;
  localparam logic [7:0] RST_LEN_LIMIT = 8'hff;
  localparam logic [7:0] RST_FILTER = 8'h04;
  localparam logic [7:0] RST_FORMAT = 8'h45;
  localparam logic [7:0] RST_NODE_ADDR = 8'h00;
  localparam logic [7:0] MASK_FILTER = 8'hef;
  localparam logic [7:0] MASK_FORMAT = 8'h77;

  localparam int BIT_FLUSH = 3;
  localparam int BIT_APPEND = 2;
  localparam int LSB_ADDR_SEL = 0;
  localparam int LSB_OUT_FMT = 4;
  localparam int BIT_CRC_EN = 2;
  localparam int LSB_LEN_CFG = 0;

  localparam logic [1:0] LEN_FIXED = 2'h0;
  localparam logic [1:0] LEN_VARIABLE = 2'h1;
  localparam logic [1:0] LEN_INFINITE = 2'h2;
  localparam logic [1:0] ADDR_NONE = 2'h0;
  localparam logic [1:0] ADDR_BCAST0 = 2'h2;
  localparam logic [1:0] ADDR_BCAST_BOTH = 2'h3;
  localparam logic [1:0] FMT_FIFO = 2'h0;
  localparam logic [1:0] FMT_SYNC_SERIAL = 2'h1;
  localparam logic [1:0] FMT_ASYNC_SERIAL = 2'h3;

  localparam logic [7:0] BCAST_LOW = 8'h00;
  localparam logic [7:0] BCAST_HIGH = 8'hff;
  localparam logic [7:0] LEN_ZERO = 8'h00;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;

  typedef enum logic [7:0] {
    RPH_HUNT = 8'h01,
    RPH_LEN = 8'h02,
    RPH_ADDR = 8'h04,
    RPH_PAY = 8'h08,
    RPH_CRC1 = 8'h10,
    RPH_CRC2 = 8'h20,
    RPH_STAT1 = 8'h40,
    RPH_STAT2 = 8'h80
  } rph_phase_t;
endpackage : rph_pkg
`default_nettype wire

// File: rph_pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module rph_pair_buffer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic rd_idx;
    logic wr_idx;
    logic [1:0] count;
  } rph_buf_t;

  rph_buf_t q;
  rph_buf_t next_q;
  logic push;
  logic pop;

  assign in_ready = (q.count != 2'h2);
  assign out_valid = (q.count != 2'h0);
  assign out_data = q.mem[q.rd_idx];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wr_idx] = in_data;
      next_q.wr_idx = ~q.wr_idx;
    end
    if (pop) begin
      next_q.rd_idx = ~q.rd_idx;
    end
    next_q.count = q.count + {1'b0, push} - {1'b0, pop};
    // flush drops both entries, including any word offered this cycle
    if (flush) begin
      next_q.rd_idx = 1'b0;
      next_q.wr_idx = 1'b0;
      next_q.count = 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : rph_pair_buffer
`default_nettype wire

// File: rph_packet_handler_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rph_packet_handler_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire logic bit_ready,
  input wire logic [7:0] rssi,
  input wire logic fifo_valid,
  input wire logic fifo_ready,
  input wire logic [7:0] fifo_data,
  input wire logic fifo_flush,
  input wire logic [1:0] general_digital_output_pins
);
  logic [7:0] fmt_reg;
  logic [7:0] next_fmt_reg;
  logic [1:0] fmt;
  always_comb begin
    next_fmt_reg = fmt_reg;
    if (reg_wr && reg_addr == rph_pkg::OFS_FORMAT) begin
      next_fmt_reg = reg_wdata & rph_pkg::MASK_FORMAT;
    end
  end
  always_ff @(posedge ref_clk) begin
    fmt_reg <= rst ? rph_pkg::RST_FORMAT : next_fmt_reg;
  end
  assign fmt = fmt_reg[rph_pkg::LSB_OUT_FMT +: 2];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_idle_a: assert property ($fell(rst) |-> reg_rdata == 8'h00 && !fifo_valid
    && !fifo_flush && general_digital_output_pins == 2'h0 && bit_ready)
    else $error("outputs not idle after reset");
  fifo_hold_a: assert property (fifo_valid && !fifo_ready && !fifo_flush
    |=> fifo_flush || (fifo_valid && $stable(fifo_data)))
    else $error("offered byte changed before accept");
  flush_pulse_a: assert property (fifo_flush |=> !fifo_flush)
    else $error("flush longer than one cycle");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 6'h3f |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  format_read_a: assert property (reg_rd && reg_addr == rph_pkg::OFS_FORMAT
    |=> reg_rdata == $past(fmt_reg))
    else $error("format register readback wrong");
  fifo_pins_a: assert property (fmt == rph_pkg::FMT_FIFO && $past(fmt) == rph_pkg::FMT_FIFO
    |-> general_digital_output_pins == 2'h0)
    else $error("pins active in fifo format");
  sync_serial_a: assert property (fmt == rph_pkg::FMT_SYNC_SERIAL && bit_valid && bit_ready
    |=> general_digital_output_pins == {1'b1, $past(bit_data)})
    else $error("sync serial output wrong");
  async_serial_a: assert property (fmt == rph_pkg::FMT_ASYNC_SERIAL && bit_valid
    && bit_ready |=> general_digital_output_pins == {1'b0, $past(bit_data)})
    else $error("async serial output wrong");
  serial_ready_a: assert property (fmt[0] |-> bit_ready)
    else $error("serial format stalled the bits");
endmodule : rph_packet_handler_sva
bind rph_packet_handler rph_packet_handler_sva u_sva (.ref_clk, .rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .bit_valid, .bit_data, .bit_ready, .rssi, .fifo_valid,
  .fifo_ready, .fifo_data, .fifo_flush, .general_digital_output_pins);
`default_nettype wire

// File: rph_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rph_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic fifo_valid,
  output logic fifo_ready = 1'b0,
  input wire logic [7:0] fifo_data,
  input wire logic fifo_flush
);
  logic [7:0] got[$];
  always @(posedge ref_clk) begin
    fifo_ready <= !stall && !rst;
    if (fifo_flush) begin
      got.delete();
    end else if (fifo_valid && fifo_ready) begin
      got.push_back(fifo_data);
    end
  end
endmodule : rph_host_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, rst, reg_wr, reg_rd, bit_valid, bit_data, bit_ready, host_stall;
  logic fifo_valid, fifo_ready, fifo_flush;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rssi, fifo_data;
  logic [1:0] general_digital_output_pins;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] body[$];
  logic [7:0] want[$];
  logic [5:0] ra[8] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h38, 6'h3f};
  logic [7:0] rv[8] = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h45, 8'h00, 8'h00, 8'h00};
  logic [1:0] am[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [7:0] aa[6] = '{8'h77, 8'h33, 8'h00, 8'h00, 8'hff, 8'hff};
  logic ok[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  rph_packet_handler u_dut (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .bit_valid, .bit_data, .bit_ready, .rssi, .fifo_valid, .fifo_ready,
    .fifo_data, .fifo_flush, .general_digital_output_pins);
  rph_host_model u_host (.ref_clk, .rst, .stall(host_stall), .fifo_valid, .fifo_ready,
    .fifo_data, .fifo_flush);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task summarize;
    $display("TB: errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask : rd
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction : crc
  // bits go out msb first, held until taken
  task send_byte(input logic [7:0] b);
    int k;
    for (int i = 7; i >= 0; i--) begin
      bit_valid <= 1'b1;
      bit_data <= b[i];
      k = 0;
      @(negedge ref_clk);
      while (bit_ready !== 1'b1 && k < 300) begin
        @(negedge ref_clk);
        k++;
      end
      if (k >= 300) begin
        num_errors++;
        summarize();
      end
      @(posedge ref_clk);
    end
  endtask : send_byte
  // how: 0 good check bytes, 1 corrupted, 2 none
  task frame(input logic [1:0] how);
    logic [15:0] c;
    c = 16'hffff;
    u_host.got.delete();
    send_byte(8'hd3);
    send_byte(8'h91);
    foreach (body[j]) begin
      c = crc(c, body[j]);
      send_byte(body[j]);
    end
    if (how != 2'h2) begin
      send_byte(c[15:8]);
      send_byte(c[7:0] ^ {7'h00, how[0]});
    end
    bit_valid <= 1'b0;
    bit_data <= ~bit_data;
    repeat (60) @(posedge ref_clk);
  endtask : frame
  task verify;
    chk(8'(u_host.got.size()), 8'(want.size()));
    foreach (want[j]) chk(u_host.got[j], want[j]);
  endtask : verify
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    bit_valid = 1'b0;
    bit_data = 1'b0;
    rssi = 8'h5a;
    host_stall = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    wr(rph_pkg::OFS_FORMAT, 8'hff);
    rd(rph_pkg::OFS_FORMAT, 8'h77);
    wr(rph_pkg::OFS_FORMAT, 8'h45);
    wr(rph_pkg::OFS_FILTER, 8'hff);
    rd(rph_pkg::OFS_FILTER, 8'hef);
    wr(rph_pkg::OFS_FILTER, 8'h04);
    body = '{8'h02, 8'ha5, 8'h3c};
    want = '{8'h02, 8'ha5, 8'h3c, 8'h5a, 8'h80};
    host_stall <= 1'b1;
    fork
      frame(2'h0);
      begin
        repeat (50) @(posedge ref_clk);
        host_stall <= 1'b0;
      end
    join
    verify();
    rd(rph_pkg::OFS_STATUS, 8'h80);
    // crc off: no check bytes, status byte reports zero
    wr(rph_pkg::OFS_FORMAT, 8'h41);
    body = '{8'h01, 8'h66};
    want = '{8'h01, 8'h66, 8'h5a, 8'h00};
    frame(2'h2);
    verify();
    rd(rph_pkg::OFS_STATUS, 8'h00);
    wr(rph_pkg::OFS_FORMAT, 8'h45);
    wr(rph_pkg::OFS_FILTER, 8'h08);
    body = '{8'h01, 8'h77};
    want.delete();
    frame(2'h1);
    verify();
    rd(rph_pkg::OFS_STATUS, 8'h00);
    wr(rph_pkg::OFS_FILTER, 8'h00);
    wr(rph_pkg::OFS_LEN_LIMIT, 8'h03);
    body = '{8'h04, 8'h01, 8'h02, 8'h03, 8'h04};
    frame(2'h0);
    verify();
    // a length equal to the limit is still accepted
    body = '{8'h03, 8'h01, 8'h02, 8'h03};
    want = body;
    frame(2'h0);
    verify();
    wr(rph_pkg::OFS_FORMAT, 8'h44);
    wr(rph_pkg::OFS_LEN_LIMIT, 8'h02);
    body = '{8'hc1, 8'hc2};
    want = body;
    frame(2'h0);
    verify();
    wr(rph_pkg::OFS_FORMAT, 8'h45);
    wr(rph_pkg::OFS_LEN_LIMIT, 8'hff);
    wr(rph_pkg::OFS_NODE_ADDR, 8'h33);
    for (int i = 0; i < 6; i++) begin
      wr(rph_pkg::OFS_FILTER, {6'h00, am[i]});
      body = '{8'h02, aa[i], 8'h11};
      want = body;
      if (!ok[i]) want.delete();
      frame(2'h0);
      verify();
    end
    wr(rph_pkg::OFS_FORMAT, 8'h46);
    body = '{8'h10, 8'h20, 8'h30};
    want = body;
    frame(2'h2);
    verify();
    rd(rph_pkg::OFS_STATUS, 8'h40);
    want.delete();
    // reserved codes deliver nothing
    wr(rph_pkg::OFS_FORMAT, 8'h65);
    frame(2'h2);
    verify();
    wr(rph_pkg::OFS_FORMAT, 8'h47);
    frame(2'h2);
    verify();
    // serial pins hold the last taken bit, a one
    body = '{8'h10, 8'h20, 8'h31};
    wr(rph_pkg::OFS_FORMAT, 8'h55);
    frame(2'h2);
    verify();
    chk({6'h00, general_digital_output_pins}, 8'h01);
    wr(rph_pkg::OFS_FORMAT, 8'h75);
    frame(2'h2);
    verify();
    chk({6'h00, general_digital_output_pins}, 8'h01);
    wr(rph_pkg::OFS_FORMAT, 8'h45);
    // a second reset restores every register
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    summarize();
  end
endmodule : testbench
`default_nettype wire
